// ===== modulo_timer_pkg.sv
// constants shared by the modulo timer design
// Behaviour
// - 8-bit up-counter runs free over full range or wraps at modulo value.
// - Prescaler input: bus clock, fixed clock, pin rising edge or pin falling edge.
// - Clock source codes 10 and 11 select the external timer clock pin.
// - Prescaler divides the selected source by 1, 2, 4 ... up to 256.
// - In wait mode a running counter keeps counting so overflow can wake.
// - Every stop mode halts the timer; it never wakes the system from stop.
// - Leaving deep stop modes, or light stop by reset, restores reset state.
// - Light stop left by interrupt keeps state; running counter resumes from count.
// - Active debug suspends counting; resumes from held count unless cleared.
// - External clock pin is synchronised to the bus clock before edge use.
// - Overflow flag bit 7 sets when counter wraps to zero from modulo value.
// - Flag clears by reading status while set, then writing zero to it.
// - Flag also clears on counter clear write or any modulo write.
// - Interrupt request while enable bit 6 and flag are set; reset clears enable.
// - Write-only clear bit 5 zeroes counter and flag; reads return zero.
// - Halt bit 4 freezes the count, clearing resumes; reset sets halt.
// - Low four status bits always read zero.
// - Counter increments to modulo, wraps to zero setting flag; modulo write resets count.
// - Modulo zero means free-running over 8 bits; reset loads modulo zero.
// - Source codes: 00 bus, 01 fixed, 10 pin falling, 11 pin rising; reset bus.
// - Prescale 0000 is /1, doubling per code to 1000 /256; others /256.
package modulo_timer_pkg;
   localparam logic [31:0] MODULO_TIMER_OFS_STATUS = 32'h0000_0000;
   localparam logic [31:0] MODULO_TIMER_OFS_CLKCFG = 32'h0000_0004;
   localparam logic [31:0] MODULO_TIMER_OFS_COUNT  = 32'h0000_0008;
   localparam logic [31:0] MODULO_TIMER_OFS_MODULO = 32'h0000_000C;
   localparam logic [31:0] MODULO_TIMER_OFS_POWER  = 32'h0000_0010;
   localparam int MODULO_TIMER_BIT_OVF  = 7;
   localparam int MODULO_TIMER_BIT_IEN  = 6;
   localparam int MODULO_TIMER_BIT_CLR  = 5;
   localparam int MODULO_TIMER_BIT_HALT = 4;
   localparam int MODULO_TIMER_CS_LSB   = 4;
   localparam int MODULO_TIMER_PS_LSB   = 0;
   localparam logic [1:0] MODULO_TIMER_CS_BUS   = 2'h0;
   localparam logic [1:0] MODULO_TIMER_CS_FIXED = 2'h1;
   localparam logic [1:0] MODULO_TIMER_CS_PINF  = 2'h2;
   localparam logic [1:0] MODULO_TIMER_CS_PINR  = 2'h3;
   localparam logic [3:0] MODULO_TIMER_PS_MAX   = 4'h8;
   localparam logic [7:0] MODULO_TIMER_RST_COUNT  = 8'h00;
   localparam logic [7:0] MODULO_TIMER_RST_MODULO = 8'h00;
   localparam logic [1:0] MODULO_TIMER_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] MODULO_TIMER_HSIZE_WORD    = 3'h2;
   // power mode codes on the power mode input
   localparam logic [1:0] MODULO_TIMER_PM_RUN   = 2'h0;
   localparam logic [1:0] MODULO_TIMER_PM_WAIT  = 2'h1;
   localparam logic [1:0] MODULO_TIMER_PM_LSTOP = 2'h3;
   localparam logic [1:0] MODULO_TIMER_PM_DSTOP = 2'h2;
endpackage : modulo_timer_pkg

// ===== modulo_timer_properties.sv
// port assertions for the modulo timer
`timescale 1ns/1ps
`default_nettype none
module modulo_timer_properties
   import modulo_timer_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        reset_i,
   input wire logic        hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic        deep_stop_wake_i,
   input wire logic        timer_irq_o
);
   logic tk;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   // address phase taken in this cycle
   assign tk = hsel_i && hready_i && htrans_i == MODULO_TIMER_HTRANS_NONSEQ;
   // the slave never stalls and never errors
   a_ready_high:
      assert property (hreadyout_o && !hresp_o) else $error("stall or error response");
   a_irq_after_reset:
      assert property ($fell(reset_i) |-> !timer_irq_o) else $error("irq out of reset");
   a_wake_clears:
      assert property (deep_stop_wake_i |=> !timer_irq_o) else $error("irq after wake");
   a_modwr_clears:
      assert property (tk && hwrite_i && haddr_i == MODULO_TIMER_OFS_MODULO |-> ##2 !timer_irq_o)
         else $error("modulo write kept flag");
   a_clrbit_clears:
      assert property (tk && hwrite_i && haddr_i == MODULO_TIMER_OFS_STATUS ##1 hwdata_i[5]
         |=> !timer_irq_o) else $error("clear bit kept flag");
   a_status_zeros:
      assert property (tk && !hwrite_i && haddr_i == MODULO_TIMER_OFS_STATUS
         |=> hrdata_o[3:0] == 4'h0 && !hrdata_o[5]) else $error("status low bits set");
   a_upper_zero:
      assert property (tk && !hwrite_i |=> hrdata_o[31:8] == 24'h000000)
         else $error("upper read bits set");
   // read data must not wander between reads, software may sample late
   a_rdata_holds:
      assert property (!(tk && !hwrite_i) |=> $stable(hrdata_o)) else $error("rdata moved");
endmodule : modulo_timer_properties
bind modulo_timer_timer modulo_timer_properties i_modulo_timer_properties (.clk_sys_i, .reset_i, .hsel_i, .haddr_i,
   .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
   .deep_stop_wake_i, .timer_irq_o);
`default_nettype wire

// ===== modulo_timer_timer.sv
// modulo timer core with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module modulo_timer_timer
   import modulo_timer_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        fixed_frequency_clock_i,
   input  wire logic        external_timer_clock_pin_i,
   input  wire logic [1:0]  power_mode_i,
   input  wire logic        deep_stop_wake_i,
   input  wire logic        debug_active_i,
   output logic             timer_irq_o
);
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] modulo;
      logic [7:0] presc;
      logic [1:0] cs;
      logic [3:0] ps;
      logic       ovf;
      logic       ien;
      logic       halt;
      logic       armed;
      logic       pin_s1;
      logic       pin_s2;
      logic       pin_s3;
      logic       fix_s1;
      logic       fix_s2;
      logic       fix_s3;
      logic       wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
   } modulo_timer_state_t;

   localparam modulo_timer_state_t MODULO_TIMER_RESET = '{
      count: MODULO_TIMER_RST_COUNT, modulo: MODULO_TIMER_RST_MODULO, presc: 8'h00,
      cs: MODULO_TIMER_CS_BUS, ps: 4'h0, ovf: 1'b0, ien: 1'b0, halt: 1'b1,
      armed: 1'b0, pin_s1: 1'b0, pin_s2: 1'b0, pin_s3: 1'b0,
      fix_s1: 1'b0, fix_s2: 1'b0, fix_s3: 1'b0, wr_pend: 1'b0,
      wr_addr: 8'h00, rdata: 32'h0000_0000};

   modulo_timer_state_t s_q;
   modulo_timer_state_t s_d;

   // prescaler tap: one-cycle tick when the low ps bits of the divider all ones
   function automatic logic modulo_timer_tap(input logic [7:0] cnt, input logic [3:0] ps);
      logic [3:0] n;
      logic [7:0] mask;
      n    = (ps > MODULO_TIMER_PS_MAX) ? MODULO_TIMER_PS_MAX : ps;
      mask = 8'((9'h001 << n) - 9'h001);
      return (cnt & mask) == mask;
   endfunction : modulo_timer_tap

   // status register view; clear bit and low nibble read zero
   function automatic logic [7:0] modulo_timer_status(input modulo_timer_state_t s);
      logic [7:0] v;
      v = 8'h00;
      v[MODULO_TIMER_BIT_OVF]  = s.ovf;
      v[MODULO_TIMER_BIT_IEN]  = s.ien;
      v[MODULO_TIMER_BIT_HALT] = s.halt;
      return v;
   endfunction : modulo_timer_status

   logic       src_edge;
   logic       stopped;
   logic       tick;
   logic       take;
   logic       deep_wake;

   // source edge select; pin edges seen on synchronised copies only
   always_comb
   begin
      case (s_q.cs)
         MODULO_TIMER_CS_BUS:   src_edge = 1'b1;
         MODULO_TIMER_CS_FIXED: src_edge = s_q.fix_s2 & ~s_q.fix_s3;
         MODULO_TIMER_CS_PINF:  src_edge = ~s_q.pin_s2 & s_q.pin_s3;
         default:       src_edge = s_q.pin_s2 & ~s_q.pin_s3;
      endcase
   end

   // stop modes freeze prescaler and counter; wait mode keeps running
   assign stopped   = (power_mode_i == MODULO_TIMER_PM_LSTOP) || (power_mode_i == MODULO_TIMER_PM_DSTOP);
   assign tick      = src_edge & ~s_q.halt & ~stopped & ~debug_active_i & modulo_timer_tap(s_q.presc, s_q.ps);
   assign take      = hsel_i & hready_i & (htrans_i == MODULO_TIMER_HTRANS_NONSEQ);
   assign deep_wake = deep_stop_wake_i;

   // next-state logic for counter, flags, registers and bus
   always_comb
   begin
      logic [7:0] wd;
      logic       clr_cnt;
      logic       ovf_set;
      wd       = hwdata_i[7:0];
      clr_cnt  = 1'b0;
      ovf_set  = 1'b0;
      s_d      = s_q;
      s_d.pin_s1 = external_timer_clock_pin_i;
      s_d.pin_s2 = s_q.pin_s1;
      s_d.pin_s3 = s_q.pin_s2;
      s_d.fix_s1 = fixed_frequency_clock_i;
      s_d.fix_s2 = s_q.fix_s1;
      s_d.fix_s3 = s_q.fix_s2;
      // prescaler free-runs on source edges while counting is allowed
      if (src_edge && !s_q.halt && !stopped && !debug_active_i)
      begin
         s_d.presc = s_q.presc + 8'h01;
      end
      if (tick)
      begin
         if (s_q.modulo != MODULO_TIMER_RST_MODULO && s_q.count == s_q.modulo)
         begin
            s_d.count = MODULO_TIMER_RST_COUNT;
            s_d.ovf   = 1'b1;
            ovf_set   = 1'b1;
         end
         else
         begin
            s_d.count = s_q.count + 8'h01;
            if (s_q.count == 8'hFF)
            begin
               s_d.ovf = 1'b1;
               ovf_set = 1'b1;
            end
         end
      end
      // address phase capture; reads answer from the data phase register
      s_d.wr_pend = take & hwrite_i & (hsize_i == MODULO_TIMER_HSIZE_WORD);
      if (take)
      begin
         s_d.wr_addr = haddr_i[7:0];
         if (!hwrite_i)
         begin
            if (haddr_i == MODULO_TIMER_OFS_STATUS)
            begin
               s_d.rdata = {24'h0, modulo_timer_status(s_q)};
               s_d.armed = s_q.ovf;
            end
            else if (haddr_i == MODULO_TIMER_OFS_CLKCFG)
               s_d.rdata = {24'h0, 2'b00, s_q.cs, s_q.ps};
            else if (haddr_i == MODULO_TIMER_OFS_COUNT)
               s_d.rdata = {24'h0, s_q.count};
            else if (haddr_i == MODULO_TIMER_OFS_MODULO)
               s_d.rdata = {24'h0, s_q.modulo};
            else if (haddr_i == MODULO_TIMER_OFS_POWER)
               s_d.rdata = {30'h0, power_mode_i};
            else
               s_d.rdata = 32'h0000_0000;
         end
      end
      // data phase write; hardware set of the flag beats a write-zero clear, but a clear-bit or modulo write clears it
      if (s_q.wr_pend)
      begin
         if ({24'h0, s_q.wr_addr} == MODULO_TIMER_OFS_STATUS)
         begin
            s_d.ien  = wd[MODULO_TIMER_BIT_IEN];
            s_d.halt = wd[MODULO_TIMER_BIT_HALT];
            // only a real overflow in this cycle beats the clear, not a plain tick
            if (!wd[MODULO_TIMER_BIT_OVF] && s_q.armed && !ovf_set)
               s_d.ovf = 1'b0;
            if (!wd[MODULO_TIMER_BIT_OVF])
               s_d.armed = 1'b0;
            if (wd[MODULO_TIMER_BIT_CLR])
               clr_cnt = 1'b1;
         end
         else if ({24'h0, s_q.wr_addr} == MODULO_TIMER_OFS_CLKCFG)
         begin
            s_d.cs = wd[MODULO_TIMER_CS_LSB +: 2];
            s_d.ps = wd[MODULO_TIMER_PS_LSB +: 4];
         end
         else if ({24'h0, s_q.wr_addr} == MODULO_TIMER_OFS_MODULO)
         begin
            s_d.modulo = wd;
            clr_cnt    = 1'b1;
         end
      end
      if (clr_cnt)
      begin
         s_d.count = MODULO_TIMER_RST_COUNT;
         s_d.presc = 8'h00;
         s_d.ovf   = 1'b0;
         s_d.armed = 1'b0;
      end
      // deep stop wake reloads the reset state; light stop left by interrupt simply resumes
      if (deep_wake)
      begin
         s_d = MODULO_TIMER_RESET;
         s_d.rdata = s_q.rdata;    // read data belongs to the bus, it must not jump on a wake
      end
   end

   // single register for the whole state
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         s_q <= MODULO_TIMER_RESET;
      else
         s_q <= s_d;
   end

   // zero wait state slave, always okay
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = s_q.rdata;
   assign timer_irq_o = s_q.ovf & s_q.ien;
endmodule : modulo_timer_timer
`default_nettype wire

// ===== tb_top.sv
// register-level bench for the modulo timer
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import modulo_timer_pkg::*;
();
   logic        clk_sys_i = 1'b0, reset_i = 1'b1, fclk = 1'b0, pin = 1'b0, wake = 1'b0;
   logic        hsel = 1'b0, hwrite = 1'b0, dbg = 1'b0, hready, hresp, irq;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rd2;
   logic [1:0]  htrans = 2'h0, pm = 2'h0;
   logic [2:0]  c8 = 3'h0;
   int          err_total = 0, n_tests = 0, cyc = 0, t1, i;
   localparam logic [1:0] PMT [6] = '{MODULO_TIMER_PM_RUN, MODULO_TIMER_PM_RUN, MODULO_TIMER_PM_WAIT,
      MODULO_TIMER_PM_LSTOP, MODULO_TIMER_PM_RUN, MODULO_TIMER_PM_DSTOP};
   modulo_timer_timer i_modulo_timer_timer (.clk_sys_i, .reset_i, .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(MODULO_TIMER_HSIZE_WORD), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .fixed_frequency_clock_i(fclk), .external_timer_clock_pin_i(pin), .power_mode_i(pm),
      .deep_stop_wake_i(wake), .debug_active_i(dbg), .timer_irq_o(irq));
   always #20 clk_sys_i = ~clk_sys_i;
   // both slow sources have period 8, the pin kept within a quarter of the bus rate
   always @(posedge clk_sys_i)
   begin
      cyc  <= cyc + 1;
      c8   <= c8 + 3'h1;
      fclk <= c8[2];
      pin  <= c8[2] ^ c8[1];
   end
   task summarize;
      if (err_total == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // at least one edge, then until hready, never unbounded
   task hw;
      int k;
      for (k = 0; k < 1 || (hready !== 1'b1 && k < 50); k++)
         @(posedge clk_sys_i);
      chk(hready, 1'b1);
      if (hready !== 1'b1)
         summarize;
   endtask : hw
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= MODULO_TIMER_HTRANS_NONSEQ;
      hw;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hw;
      rd = hrdata;
   endtask : xfer
   task wirq(output int t);
      int k;
      for (k = 0; k < 9000 && irq !== 1'b1; k++)
         @(posedge clk_sys_i);
      chk(irq, 1'b1);
      if (irq !== 1'b1)
         summarize;
      t = cyc;
   endtask : wirq
   // overflow to overflow spacing, flag cleared in between by the read-then-write order
   task period(input logic [7:0] cfg, input logic [7:0] m, input int exp);
      int t2;
      xfer(1'b1, MODULO_TIMER_OFS_CLKCFG, {24'h0, cfg});
      xfer(1'b1, MODULO_TIMER_OFS_MODULO, {24'h0, m});
      xfer(1'b1, MODULO_TIMER_OFS_STATUS, 32'h40);
      wirq(t1);
      xfer(1'b1, MODULO_TIMER_OFS_STATUS, 32'h40);
      @(posedge clk_sys_i);
      chk(irq, 1'b1);
      xfer(1'b0, MODULO_TIMER_OFS_STATUS, 32'h0);
      chk(rd, 32'hC0);
      xfer(1'b1, MODULO_TIMER_OFS_STATUS, 32'h40);
      @(posedge clk_sys_i);
      chk(irq, 1'b0);
      wirq(t2);
      chk(t2 - t1, exp);
   endtask : period
   // two count reads a few cycles apart tell whether the counter moves
   task mode(input logic [1:0] p, input logic d, input logic m);
      pm  <= p;
      dbg <= d;
      repeat (2) @(posedge clk_sys_i);
      xfer(1'b0, MODULO_TIMER_OFS_COUNT, 32'h0);
      rd2 = rd;
      xfer(1'b0, MODULO_TIMER_OFS_COUNT, 32'h0);
      chk(rd !== rd2, m);
   endtask : mode
   initial
   begin
      repeat (3) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      xfer(1'b0, MODULO_TIMER_OFS_STATUS, 32'h0);
      chk(rd, 32'h10);
      for (i = 1; i < 9; i++)
      begin
         xfer(1'b0, 4 * i, 32'h0);
         chk(rd, 32'h0);
      end
      xfer(1'b1, MODULO_TIMER_OFS_COUNT, 32'h55);
      xfer(1'b0, MODULO_TIMER_OFS_COUNT, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, MODULO_TIMER_OFS_CLKCFG, 32'hFF);
      xfer(1'b0, MODULO_TIMER_OFS_CLKCFG, 32'h0);
      chk(rd, 32'h3F);
      for (i = 0; i < 10; i++)
         period({4'h0, (i == 9) ? 4'hF : i[3:0]}, 8'h0F, 16 << ((i > 8) ? 8 : i));
      for (i = 1; i < 4; i++)
         period({2'h0, i[1:0], 4'h0}, 8'h0F, 128);
      period(8'h00, 8'h00, 256);
      xfer(1'b1, MODULO_TIMER_OFS_STATUS, 32'h30);
      xfer(1'b0, MODULO_TIMER_OFS_COUNT, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b0, MODULO_TIMER_OFS_STATUS, 32'h0);
      chk(rd, 32'h10);
      xfer(1'b0, MODULO_TIMER_OFS_COUNT, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, MODULO_TIMER_OFS_STATUS, 32'h0);
      for (i = 0; i < 6; i++)
         mode(PMT[i], i == 1, !i[0]);
      wake <= 1'b1;
      @(posedge clk_sys_i);
      wake <= 1'b0;
      pm   <= MODULO_TIMER_PM_RUN;
      xfer(1'b0, MODULO_TIMER_OFS_STATUS, 32'h0);
      chk(rd, 32'h10);
      summarize;
   end
endmodule : tb_top
`default_nettype wire
